// ### spo_pkg.sv
package spo_pkg;

  // operating modes of the output port
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_VIDEO,
    MODE_ASI,
    MODE_THRU
  } spo_mode_e;

  // rate codes {bit1, bit0}: bit0 high = SD, else bit1 high = 3G, else HD
  localparam logic [1:0]  RATE_HD        = 2'h0;
  localparam logic [1:0]  RATE_SD        = 2'h1;
  localparam logic [1:0]  RATE_3G        = 2'h2;

  // register offsets
  localparam logic [11:0] REG_CTRL       = 12'h000;
  localparam logic [11:0] REG_STATUS     = 12'h004;
  localparam logic [11:0] REG_DLY        = 12'h06c;

  // reset values and writable masks
  localparam logic [15:0] CTRL_RST       = 16'h0001;
  localparam logic [15:0] CTRL_MASK      = 16'h000f;
  localparam logic [15:0] DLY_RST        = 16'h0000;
  localparam logic [15:0] DLY_MASK       = 16'h003f;

  // field positions
  localparam int          CTRL_AUTO_BIT  = 0;
  localparam int          CTRL_RATE_LSB  = 1;
  localparam int          CTRL_SWAP_BIT  = 3;
  localparam int          DLY_QUAD_BIT   = 5;
  localparam int          DLY_FINE_MSB   = 4;
  localparam int          ST_RATE_LSB    = 0;
  localparam int          ST_MODE_LSB    = 2;
  localparam int          ST_DDR_BIT     = 4;

  // delay line step and span, analog cell outside this logic
  localparam int          DLY_STEP_PS    = 40;
  localparam int          DLY_MAX_PS     = 1200;

  // pixel clock divide ratios from a 297 MHz link word clock
  localparam logic [4:0]  DIV_3G         = 5'h02;
  localparam logic [4:0]  DIV_HD10       = 5'h02;
  localparam logic [4:0]  DIV_HD20       = 5'h04;
  localparam logic [4:0]  DIV_SD10       = 5'h0b;
  localparam logic [4:0]  DIV_SD20       = 5'h16;

  function automatic logic rate_is_sd(input logic [1:0] r);
    return r[0];
  endfunction

  function automatic logic rate_is_3g(input logic [1:0] r);
    return !r[0] && r[1];
  endfunction

  // pixel clock ratio for mode, width and rate
  function automatic logic [4:0] div_for(input spo_mode_e  m,
                                         input logic       wide,
                                         input logic [1:0] r);
    logic [4:0] d;
    d = DIV_HD10;
    if (m == MODE_ASI) begin
      d = DIV_SD10;
    end else if (rate_is_sd(r)) begin
      d = wide ? DIV_SD20 : DIV_SD10;
    end else if (rate_is_3g(r)) begin
      d = DIV_3G;
    end else begin
      d = wide ? DIV_HD20 : DIV_HD10;
    end
    return d;
  endfunction

endpackage

// ### spo_clk_if.sv
`timescale 1ns/1ps
interface spo_clk_if;
  logic [4:0] div;
  logic       ddr;
  logic       tick;
  logic       pclk;

  modport gen (
    input  div,
    input  ddr,
    output tick,
    output pclk
  );

  modport user (
    output div,
    output ddr,
    input  tick,
    input  pclk
  );
endinterface

// ### spo_sync.sv
`timescale 1ns/1ps
module spo_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // level in and synchronised level out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  always_comb begin
    nxt_meta = i_d;
    nxt_q    = meta_ff;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_ff <= RST_VAL;
      q_ff    <= RST_VAL;
    end else begin
      meta_ff <= nxt_meta;
      q_ff    <= nxt_q;
    end
  end

  assign o_q = q_ff;

endmodule // spo_sync

// ### spo_clkgen.sv
`timescale 1ns/1ps
module spo_clkgen (
  // link clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // divide control and pixel clock
  spo_clk_if.gen    clk_if
);

  logic [4:0] cnt_ff;
  logic       pclk_ff;
  logic [4:0] nxt_cnt;
  logic       nxt_pclk;
  logic [4:0] half;

  // counter wraps even when the ratio shrinks mid-period
  always_comb begin
    half = clk_if.div >> 1;
    if (cnt_ff >= clk_if.div - 5'h01) begin
      nxt_cnt = 5'h00;
    end else begin
      nxt_cnt = cnt_ff + 5'h01;
    end
    // rise only at wrap, so a ratio change cannot glitch the clock
    nxt_pclk = (nxt_cnt == 5'h00) || (pclk_ff && (nxt_cnt < half));
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_ff  <= 5'h00;
      pclk_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      pclk_ff <= nxt_pclk;
    end
  end

  // ddr moves a word on every link clock rise, else once per pixel period
  assign clk_if.tick = (cnt_ff == 5'h00) || clk_if.ddr;
  assign clk_if.pclk = pclk_ff;

endmodule // spo_clkgen

// ### spo_top.sv
// Behaviour
// RULE_01 - video mode: width pin picks mux or demux
// RULE_02 - 20-bit video: luma/chroma or streams side by side
// RULE_03 - 10-bit video: interleave on upper bits, lower low
// RULE_04 - ASI only with manual rate, pins LOW/HIGH
// RULE_05 - board keeps width pin LOW during ASI
// RULE_06 - ASI byte on bits 17:10, LSB bit 10
// RULE_07 - ASI: bit 19 code error, bit 18 comma
// RULE_08 - comma flag high on K28.5 words only
// RULE_09 - code error on disparity or illegal code
// RULE_10 - data-through forwards raw data unprocessed
// RULE_11 - data-through width follows width pin
// RULE_12 - no 3G level B input when entering through
// RULE_13 - 20-bit clocks: HD 74.25, SD 13.5, 3G 148.5
// RULE_14 - 10-bit clocks: HD/3G 148.5, SD/ASI 27
// RULE_15 - rate from manual or detected by auto bit
// RULE_16 - DDR only for 3G at 10-bit width
// RULE_17 - receiver samples DDR words on both edges
// RULE_18 - delay bit 5 selects quadrature clock phase
// RULE_19 - delay bits 4:0 fine clock delay steps
// RULE_20 - software may swap 3G streams on bus
// RULE_21 - ASI holds lower ten bits LOW
`timescale 1ns/1ps
module spo_top (
  // register side clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_B,
  // register port
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  input  wire logic [11:0] I_REG_ADDR,
  input  wire logic [15:0] I_REG_WDATA,
  output logic      [15:0] O_REG_RDATA,
  // recovered word clock
  input  wire logic        I_LINK_CLK,
  // mode pins
  input  wire logic        I_VIDEO_PROCESSING_SELECT,
  input  wire logic        I_TRANSPORT_MODE_PIN,
  input  wire logic        I_BUS_WIDTH_SELECT,
  // rate detector, link domain
  input  wire logic        I_DETECTED_RATE_BIT0,
  input  wire logic        I_DETECTED_RATE_BIT1,
  // recovered stream, link domain
  input  wire logic [9:0]  I_LUMA,
  input  wire logic [9:0]  I_CHROMA,
  input  wire logic [19:0] I_RAW,
  input  wire logic [7:0]  I_ASI_BYTE,
  input  wire logic        I_ASI_COMMA,
  input  wire logic        I_ASI_CODE_ERR,
  output logic             O_WORD_TAKE,
  // parallel output port
  output logic [19:0]      O_DOUT,
  output logic             O_PCLK,
  output logic             O_CLOCK_QUADRATURE_SELECT,
  output logic [4:0]       O_CLOCK_FINE_DELAY
);

  // ---------------- register side ----------------
  logic [15:0]          ctrl_ff;
  logic [15:0]          dly_ff;
  logic [15:0]          rdata_ff;
  logic [15:0]          nxt_ctrl;
  logic [15:0]          nxt_dly;
  logic [15:0]          nxt_rdata;
  logic [4:0]           status_sync;

  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_dly   = dly_ff;
    nxt_rdata = rdata_ff;
    if (I_REG_WR) begin
      case (I_REG_ADDR)
        spo_pkg::REG_CTRL: nxt_ctrl = I_REG_WDATA & spo_pkg::CTRL_MASK;
        spo_pkg::REG_DLY:  nxt_dly  = I_REG_WDATA & spo_pkg::DLY_MASK;
        default:           nxt_ctrl = ctrl_ff;
      endcase
    end
    if (I_REG_RD) begin
      case (I_REG_ADDR)
        spo_pkg::REG_CTRL:   nxt_rdata = ctrl_ff;
        spo_pkg::REG_STATUS: nxt_rdata = {11'h000, status_sync};
        spo_pkg::REG_DLY:    nxt_rdata = dly_ff;
        default:             nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_ff  <= spo_pkg::CTRL_RST;
      dly_ff   <= spo_pkg::DLY_RST;
      rdata_ff <= 16'h0000;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      dly_ff   <= nxt_dly;
      rdata_ff <= nxt_rdata;
    end
  end

  assign O_REG_RDATA = rdata_ff;

  // ---------------- crossings ----------------
  logic                 link_rst_b;
  logic [2:0]           pins_l;
  logic [9:0]           cfg_l;
  logic [4:0]           status_l;

  // reset release aligned to the link clock
  spo_sync #(.W(1), .RST_VAL(1'b0)) u_link_rst (
    .i_clk   (I_LINK_CLK),
    .i_rst_b (I_RST_B),
    .i_d     (1'b1),
    .o_q     (link_rst_b)
  );

  spo_sync #(.W(3), .RST_VAL(3'h0)) u_pins (
    .i_clk   (I_LINK_CLK),
    .i_rst_b (link_rst_b),
    .i_d     ({I_VIDEO_PROCESSING_SELECT, I_TRANSPORT_MODE_PIN,
               I_BUS_WIDTH_SELECT}),
    .o_q     (pins_l)
  );

  // quasi-static software settings into the link domain
  spo_sync #(.W(10), .RST_VAL(10'h001)) u_cfg (
    .i_clk   (I_LINK_CLK),
    .i_rst_b (link_rst_b),
    .i_d     ({dly_ff[5:0], ctrl_ff[3:0]}),
    .o_q     (cfg_l)
  );

  spo_sync #(.W(5), .RST_VAL(5'h00)) u_status (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_d     (status_l),
    .o_q     (status_sync)
  );

  // ---------------- link side ----------------
  spo_clk_if clk_if ();

  spo_clkgen u_clkgen (
    .i_clk   (I_LINK_CLK),
    .i_rst_b (link_rst_b),
    .clk_if  (clk_if)
  );

  typedef spo_pkg::spo_mode_e spo_mode_e_t;

  logic                 vps_l;
  logic                 tmp_l;
  logic                 wide_l;
  logic                 auto_l;
  logic                 swap_l;
  logic [1:0]           man_rate_l;
  logic [1:0]           det_rate;
  logic [1:0]           rate_sel;
  logic                 asi_cond;
  spo_mode_e_t          mode_ff;
  spo_mode_e_t          nxt_mode;
  logic                 wide_ff;
  logic                 nxt_wide;
  logic [1:0]           rate_ff;
  logic [1:0]           nxt_rate;
  logic                 ddr_ff;
  logic                 nxt_ddr;
  logic                 ph_ff;
  logic                 nxt_ph;
  logic [9:0]           hold_ff;
  logic [9:0]           nxt_hold;
  logic [19:0]          dout_ff;
  logic [19:0]          nxt_dout;
  logic [5:0]           dly_l;
  logic                 mux10;
  logic                 is3g;
  logic [9:0]           first_w;
  logic [9:0]           second_w;

  assign vps_l      = pins_l[2];
  assign tmp_l      = pins_l[1];
  assign wide_l     = pins_l[0];
  assign auto_l     = cfg_l[spo_pkg::CTRL_AUTO_BIT];
  assign man_rate_l = cfg_l[spo_pkg::CTRL_RATE_LSB +: 2];
  assign swap_l     = cfg_l[spo_pkg::CTRL_SWAP_BIT];
  assign dly_l      = cfg_l[9:4];
  assign det_rate   = {I_DETECTED_RATE_BIT1, I_DETECTED_RATE_BIT0};

  // RULE_15 rate source select
  assign rate_sel = auto_l ? det_rate : man_rate_l;
  // RULE_04 transport mode gate
  assign asi_cond = !auto_l && !vps_l && tmp_l;

  always_comb begin
    nxt_wide = wide_l;
    nxt_rate = rate_sel;
    // RULE_01 video mode entry
    if (vps_l && !tmp_l) begin
      nxt_mode = spo_pkg::MODE_VIDEO;
    end else if (asi_cond) begin
      nxt_mode = spo_pkg::MODE_ASI;
    // RULE_10 data-through entry
    end else if (!vps_l && !tmp_l) begin
      nxt_mode = spo_pkg::MODE_THRU;
    end else begin
      nxt_mode = spo_pkg::MODE_IDLE;
    end
    // RULE_16 ddr only 3G narrow
    nxt_ddr = (nxt_mode == spo_pkg::MODE_VIDEO) && !wide_l &&
              spo_pkg::rate_is_3g(rate_sel);
  end

  always_ff @(posedge I_LINK_CLK or negedge link_rst_b) begin
    if (!link_rst_b) begin
      mode_ff <= spo_pkg::MODE_IDLE;
      wide_ff <= 1'b0;
      rate_ff <= spo_pkg::RATE_HD;
      ddr_ff  <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      wide_ff <= nxt_wide;
      rate_ff <= nxt_rate;
      ddr_ff  <= nxt_ddr;
    end
  end

  // RULE_13 wide clock ratios
  // RULE_14 narrow clock ratios
  assign clk_if.div = spo_pkg::div_for(mode_ff, wide_ff, rate_ff);
  assign clk_if.ddr = ddr_ff;

  assign mux10 = (mode_ff == spo_pkg::MODE_VIDEO) && !wide_ff;
  assign is3g  = spo_pkg::rate_is_3g(rate_ff);

  // RULE_20 stream swap
  always_comb begin
    if (is3g) begin
      first_w  = swap_l ? I_CHROMA : I_LUMA;
      second_w = swap_l ? I_LUMA : I_CHROMA;
    end else begin
      first_w  = I_CHROMA;
      second_w = I_LUMA;
    end
  end

  always_comb begin
    nxt_dout = dout_ff;
    nxt_hold = hold_ff;
    nxt_ph   = mux10 ? ph_ff : 1'b0;
    if (clk_if.tick) begin
      case (mode_ff)
        spo_pkg::MODE_VIDEO: begin
          if (wide_ff) begin
            // RULE_02 side by side words
            nxt_dout = {first_w, second_w};
            if (!is3g) begin
              nxt_dout = {I_LUMA, I_CHROMA};
            end
          end else begin
            // RULE_03 interleave, lower bits low
            nxt_dout = ph_ff ? {hold_ff, 10'h000} : {first_w, 10'h000};
            nxt_hold = ph_ff ? hold_ff : second_w;
            nxt_ph   = ddr_ff ? clk_if.pclk : !ph_ff;
          end
        end
        spo_pkg::MODE_ASI: begin
          // RULE_06 byte placement
          // RULE_07 flag positions
          // RULE_08 comma flag
          // RULE_09 code error flag
          // RULE_21 lower bits low
          nxt_dout = {I_ASI_CODE_ERR, I_ASI_COMMA, I_ASI_BYTE, 10'h000};
        end
        spo_pkg::MODE_THRU: begin
          // RULE_11 through width
          nxt_dout = wide_ff ? I_RAW : {I_RAW[9:0], 10'h000};
        end
        default: nxt_dout = 20'h00000;
      endcase
    end
  end

  always_ff @(posedge I_LINK_CLK or negedge link_rst_b) begin
    if (!link_rst_b) begin
      dout_ff <= 20'h00000;
      hold_ff <= 10'h000;
      ph_ff   <= 1'b0;
    end else begin
      dout_ff <= nxt_dout;
      hold_ff <= nxt_hold;
      ph_ff   <= nxt_ph;
    end
  end

  // second word of a 10-bit pair comes from the hold register
  assign O_WORD_TAKE = clk_if.tick && !(mux10 && ph_ff);
  assign O_DOUT      = dout_ff;
  assign O_PCLK      = clk_if.pclk;
  // RULE_18 quadrature phase select
  assign O_CLOCK_QUADRATURE_SELECT = dly_l[spo_pkg::DLY_QUAD_BIT];
  // RULE_19 fine delay code
  assign O_CLOCK_FINE_DELAY        = dly_l[spo_pkg::DLY_FINE_MSB:0];
  assign status_l = {ddr_ff, 2'(mode_ff), rate_ff};

  // ---------------- checks ----------------
  property p_asi_gate;
    @(posedge I_LINK_CLK) disable iff (!link_rst_b)
      (mode_ff == spo_pkg::MODE_ASI) |-> $past(asi_cond);
  endproperty
  a_asi_gate: assert property (p_asi_gate) // RULE_04
    else $error("asi mode without its pin and bit setting");

  property p_asi_byte;
    @(posedge I_LINK_CLK) disable iff (!link_rst_b)
      (clk_if.tick && mode_ff == spo_pkg::MODE_ASI) |=>
        (O_DOUT[17:10] == $past(I_ASI_BYTE)) && (O_DOUT[9:0] == 10'h000);
  endproperty
  a_asi_byte: assert property (p_asi_byte) // RULE_06
    else $error("asi byte misplaced or lower bits not low");

  property p_asi_flags;
    @(posedge I_LINK_CLK) disable iff (!link_rst_b)
      (clk_if.tick && mode_ff == spo_pkg::MODE_ASI) |=>
        (O_DOUT[19] == $past(I_ASI_CODE_ERR)) &&
        (O_DOUT[18] == $past(I_ASI_COMMA));
  endproperty
  a_asi_flags: assert property (p_asi_flags) // RULE_07
    else $error("asi status flags wrong");

  property p_wide_video;
    @(posedge I_LINK_CLK) disable iff (!link_rst_b)
      (clk_if.tick && mode_ff == spo_pkg::MODE_VIDEO && wide_ff && !is3g)
        |=> (O_DOUT == {$past(I_LUMA), $past(I_CHROMA)});
  endproperty
  a_wide_video: assert property (p_wide_video) // RULE_02
    else $error("20-bit luma and chroma not side by side");

  property p_swap_3g;
    @(posedge I_LINK_CLK) disable iff (!link_rst_b)
      (clk_if.tick && mode_ff == spo_pkg::MODE_VIDEO && wide_ff && is3g &&
       swap_l) |=> (O_DOUT == {$past(I_CHROMA), $past(I_LUMA)});
  endproperty
  a_swap_3g: assert property (p_swap_3g) // RULE_20
    else $error("3G streams not swapped");

  property p_narrow_low;
    @(posedge I_LINK_CLK) disable iff (!link_rst_b)
      (clk_if.tick && mux10 && !ph_ff) |=>
        (O_DOUT[9:0] == 10'h000) ##1 (O_DOUT[9:0] == 10'h000);
  endproperty
  a_narrow_low: assert property (p_narrow_low) // RULE_03
    else $error("10-bit video lower bits not low");

  property p_thru_wide;
    @(posedge I_LINK_CLK) disable iff (!link_rst_b)
      (clk_if.tick && mode_ff == spo_pkg::MODE_THRU && wide_ff) |=>
        (O_DOUT == $past(I_RAW));
  endproperty
  a_thru_wide: assert property (p_thru_wide) // RULE_11
    else $error("20-bit data-through not forwarded");

  property p_sd20_period;
    @(posedge I_LINK_CLK) disable iff (!link_rst_b)
      ($rose(O_PCLK) && clk_if.div == spo_pkg::DIV_SD20) |->
        ##22 ($rose(O_PCLK) || clk_if.div != spo_pkg::DIV_SD20);
  endproperty
  a_sd20_period: assert property (p_sd20_period) // RULE_13
    else $error("SD 20-bit pixel clock period wrong");

  property p_ddr_clock;
    @(posedge I_LINK_CLK) disable iff (!link_rst_b)
      ($rose(O_PCLK) && ddr_ff && $past(ddr_ff)) |->
        O_WORD_TAKE ##1 (!O_PCLK && !O_WORD_TAKE) ##1 ($rose(O_PCLK) || !ddr_ff);
  endproperty
  a_ddr_clock: assert property (p_ddr_clock) // RULE_16
    else $error("ddr clock or word pacing wrong");

  property p_quad_sel;
    @(posedge I_CLK) disable iff (!I_RST_B)
      $rose(dly_ff[spo_pkg::DLY_QUAD_BIT]) |->
        ##[1:8] O_CLOCK_QUADRATURE_SELECT;
  endproperty
  a_quad_sel: assert property (p_quad_sel) // RULE_18
    else $error("quadrature select not applied");

endmodule // spo_top

// ### spo_sink.sv
`timescale 1ns/1ps
module spo_sink (
  // link clock and parallel port
  input  wire logic        i_link_clk,
  input  wire logic        i_pclk,
  input  wire logic        i_ddr,
  input  wire logic [19:0] i_dout,
  input  wire logic        i_take,
  // word take seen at the last two clock rises
  output logic      [1:0]  o_take,
  // captured word, clock period in link cycles, sample count
  output logic      [19:0] o_word,
  output int               o_period,
  output int               o_count
);
  logic pclk_ff = 1'b1;
  int   cnt_ff  = 0;

  initial begin
    o_word   = '0;
    o_period = 0;
    o_count  = 0;
    o_take   = '0;
  end

  // capture on clock rise; in ddr also on the fall
  // both edges
  always @(posedge i_link_clk) begin
    pclk_ff <= i_pclk;
    cnt_ff  <= cnt_ff + 1;
    if (i_pclk && !pclk_ff) begin
      o_period <= cnt_ff + 1;
      cnt_ff   <= 0;
      o_word   <= i_dout;
      o_take   <= {o_take[0], i_take};
      o_count  <= o_count + 1;
    end else if (i_ddr && !i_pclk && pclk_ff) begin
      o_word  <= i_dout;
      o_count <= o_count + 1;
    end
  end
endmodule // spo_sink

// ### spo_top_bench.sv
`timescale 1ns/1ps
module spo_top_bench;
  typedef struct {logic [15:0] exp; string what;} spo_rd_s;
  typedef struct {logic [19:0] wa; logic [19:0] wb; int per;
                  logic [1:0] tk;} spo_vid_s;

  logic        clk       = 1'b0;
  logic        link_clk  = 1'b0;
  logic        rst_b     = 1'b0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        rd_p      = 1'b0;
  logic [11:0] reg_addr  = '0;
  logic [15:0] reg_wdata = '0;
  logic [15:0] reg_rdata;
  logic        vps       = 1'b0;
  logic        tms       = 1'b0;
  logic        wide      = 1'b0;
  logic [1:0]  det       = '0;
  logic [9:0]  luma      = '0;
  logic [9:0]  chroma    = '0;
  logic [19:0] raw       = '0;
  logic [7:0]  asi_byte  = '0;
  logic        asi_comma = 1'b0;
  logic        asi_err   = 1'b0;
  logic        ddr_mode  = 1'b0;
  logic        word_take;
  logic [19:0] dout;
  logic        pclk;
  logic        quad;
  logic [4:0]  fine;
  logic [19:0] smp_word;
  int          smp_period;
  int          smp_count;
  logic [1:0]  smp_take;
  logic [9:0]  y;
  logic [9:0]  c;
  logic [19:0] r;
  logic [7:0]  b;
  logic        cm;
  logic        er;
  int          num_errors  = 0;
  int          check_count = 0;
  spo_rd_s     rq[$];
  spo_vid_s    vq[$];
  event        probe_ev;

  initial begin
    forever #25 clk = ~clk;
  end

  initial begin
    #13;
    forever #32 link_clk = ~link_clk;
  end

  spo_top u_spo_top (
    .I_CLK(clk), .I_RST_B(rst_b), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd),
    .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
    .O_REG_RDATA(reg_rdata), .I_LINK_CLK(link_clk),
    .I_VIDEO_PROCESSING_SELECT(vps), .I_TRANSPORT_MODE_PIN(tms),
    .I_BUS_WIDTH_SELECT(wide), .I_DETECTED_RATE_BIT0(det[0]),
    .I_DETECTED_RATE_BIT1(det[1]), .I_LUMA(luma), .I_CHROMA(chroma),
    .I_RAW(raw), .I_ASI_BYTE(asi_byte), .I_ASI_COMMA(asi_comma),
    .I_ASI_CODE_ERR(asi_err), .O_WORD_TAKE(word_take), .O_DOUT(dout),
    .O_PCLK(pclk), .O_CLOCK_QUADRATURE_SELECT(quad),
    .O_CLOCK_FINE_DELAY(fine)
  );

  spo_sink u_spo_sink (
    .i_link_clk(link_clk), .i_pclk(pclk), .i_ddr(ddr_mode),
    .i_dout(dout), .i_take(word_take), .o_take(smp_take),
    .o_word(smp_word), .o_period(smp_period),
    .o_count(smp_count)
  );

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string w, input logic [19:0] e,
                     input logic [19:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    #2;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk);
    #2;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e,
                    input string w);
    rq.push_back('{exp: e, what: w});
    @(posedge clk);
    #2;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #2;
    reg_rd = 1'b0;
  endtask

  // register read results, one cycle after the read edge
  always @(posedge clk) begin
    if (rd_p && rq.size() > 0) begin
      spo_rd_s e;
      e = rq.pop_front();
      chk(e.what, {4'h0, e.exp}, {4'h0, reg_rdata});
    end
    rd_p <= reg_rd;
  end

  // bus results, taken by the sink at the pixel clock
  initial begin
    spo_vid_s v;
    int       n;
    int       k;
    forever begin
      @(probe_ev);
      v = vq.pop_front();
      if (v.per == 0) begin
        chk("idle bus", v.wa, dout);
      end else begin
        n = smp_count;
        for (k = 0; k < 400 && smp_count < n + 3; k++) @(posedge link_clk);
        #1;
        if (k == 400) begin
          num_errors++;
          $display("[ERR] sink expected samples seen none");
          report_and_stop();
        end
        check_count++;
        if (smp_word !== v.wa && smp_word !== v.wb) begin
          num_errors++;
          $display("[ERR] bus word expected %h or %h seen %h",
                   v.wa, v.wb, smp_word);
        end
        chk("pclk period", 20'(v.per), 20'(smp_period));
        if (v.tk == 2'h3) begin
          chk("word take", 20'h3, {18'h0, smp_take});
        end else begin
          chk("word take pair", 20'h1, {19'h0, ^smp_take});
        end
      end
      chk("quadrature", 20'h1, {19'h0, quad});
      chk("fine delay", 20'h14, {15'h0, fine});
    end
  end

  task automatic rnd();
    y  = 10'($urandom);
    c  = 10'($urandom);
    r  = 20'($urandom);
    b  = 8'($urandom);
    {er, cm} = 2'($urandom);
  endtask

  task automatic run_case(input logic p, input logic t, input logic w,
                          input logic [15:0] ctl, input logic [1:0] d,
                          input logic [19:0] wa, input logic [19:0] wb,
                          input int per, input logic dd,
                          input logic [4:0] st);
    @(posedge clk);
    #2;
    vps       = p;
    tms       = t;
    wide      = w;
    det       = d;
    ddr_mode  = dd;
    luma      = y;
    chroma    = c;
    raw       = r;
    asi_byte  = b;
    asi_comma = cm;
    asi_err   = er;
    wr(spo_pkg::REG_CTRL, ctl);
    repeat (80) @(posedge clk);
    vq.push_back('{wa: wa, wb: wb, per: per,
                   tk: (p && !t && !w && !dd) ? 2'h1 : 2'h3});
    ->probe_ev;
    rd(spo_pkg::REG_STATUS, {11'h0, st}, "status");
    repeat (200) @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("[ERR] run length expected end seen none");
    report_and_stop();
  end

  initial begin
    void'($urandom(9));
    repeat (4) @(posedge clk);
    #2;
    rst_b = 1'b1;
    rd(spo_pkg::REG_CTRL, spo_pkg::CTRL_RST, "ctrl reset");
    rd(spo_pkg::REG_DLY, spo_pkg::DLY_RST, "delay reset");
    rd(12'h010, 16'h0000, "unmapped");
    wr(spo_pkg::REG_DLY, 16'hffff);
    rd(spo_pkg::REG_DLY, 16'h003f, "delay mask");
    wr(12'h010, 16'h5a5a);
    rd(12'h010, 16'h0000, "unmapped write");
    wr(spo_pkg::REG_DLY, 16'h0034);
    rd(spo_pkg::REG_DLY, 16'h0034, "delay");
    rnd();
    run_case(1, 0, 1, 16'h0, 2'h2, {y, c}, {y, c}, 4, 0, 5'h04);
    rnd();
    run_case(1, 0, 1, 16'h2, 2'h0, {y, c}, {y, c}, 22, 0, 5'h05);
    rnd();
    run_case(1, 0, 1, 16'h4, 2'h0, {y, c}, {y, c}, 2, 0, 5'h06);
    rnd();
    run_case(1, 0, 1, 16'hc, 2'h0, {c, y}, {c, y}, 2, 0, 5'h06);
    rnd();
    run_case(1, 0, 0, 16'h0, 2'h0, {y, 10'h0}, {c, 10'h0}, 2, 0,
             5'h04);
    rnd();
    run_case(1, 0, 0, 16'h2, 2'h0, {y, 10'h0}, {c, 10'h0}, 11, 0,
             5'h05);
    rnd();
    run_case(1, 0, 0, 16'h4, 2'h0, {y, 10'h0}, {c, 10'h0}, 2, 1,
             5'h16);
    rnd();
    run_case(1, 0, 1, 16'h1, 2'h1, {y, c}, {y, c}, 22, 0, 5'h05);
    for (int k = 0; k < 4; k++) begin
      rnd();
      {er, cm} = 2'(k);
      // width pin held low while in transport mode
      run_case(0, 1, 0, 16'h2, 2'h0, {er, cm, b, 10'h0},
               {er, cm, b, 10'h0}, 11, 0, 5'h09);
    end
    rnd();
    run_case(0, 1, 0, 16'h3, 2'h1, 20'h0, 20'h0, 0, 0, 5'h01);
    rnd();
    // no level B input while entering data-through
    run_case(0, 0, 1, 16'h0, 2'h0, r, r, 4, 0, 5'h0c);
    rnd();
    run_case(0, 0, 0, 16'h0, 2'h0, {r[9:0], 10'h0}, {r[9:0], 10'h0}, 2,
             0, 5'h0c);
    rnd();
    run_case(1, 1, 0, 16'h0, 2'h0, 20'h0, 20'h0, 0, 0, 5'h00);
    report_and_stop();
  end
endmodule // spo_top_bench
